// ==== common/sdc_pkg.sv ====
// constants shared by the serial video driver control block
package sdc_pkg;
  // ****************************************
  // clock and bus timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned T_BUF_NS       = 4700;
  localparam int unsigned T_HIGH_MAX_NS  = 50000;
  localparam int unsigned T_TERM_NS      = 4000000;
  localparam int unsigned BUF_CYC        = (T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HIGH_MAX_CYC   = T_HIGH_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned TERM_CYC       = (T_TERM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IDLE_CNT_W     = 12;

  // ****************************************
  // bus address and register map
  // ****************************************
  localparam logic [6:0] DEV_ADDR_RST    = 7'h17;
  localparam logic [7:0] REG_ID          = 8'h00;
  localparam logic [7:0] REG_STATUS      = 8'h01;
  localparam logic [7:0] REG_CTRL        = 8'h02;
  localparam logic [7:0] REG_CFG         = 8'h03;
  localparam logic [2:0] CTRL_RST        = 3'h0;
  localparam logic [6:0] CFG_RST         = 7'h00;

  // ctrl register bits (held in [7:5] of the register)
  localparam int unsigned CTRL_SD_BIT    = 2;
  localparam int unsigned CTRL_PD_B_BIT  = 1;
  localparam int unsigned CTRL_PD_A_BIT  = 0;
  localparam int unsigned CTRL_LSB       = 5;
  // cfg register bits
  localparam int unsigned CFG_MASK_LOS   = 0;
  localparam int unsigned CFG_MASK_TF_LO = 1;
  localparam int unsigned CFG_LOS_MUTE   = 5;
  localparam int unsigned CFG_LOS_LINK   = 6;

  // ****************************************
  // bus target states
  // ****************************************
  typedef enum logic [2:0] {
    SDC_IDLE = 3'b000,
    SDC_RX   = 3'b001,
    SDC_AWT  = 3'b010,
    SDC_ACK  = 3'b011,
    SDC_TX   = 3'b100,
    SDC_HACK = 3'b101,
    SDC_IGN  = 3'b110
  } sdc_state_t;

  typedef enum logic [1:0] {
    SDC_K_ADDR = 2'b00,
    SDC_K_REG  = 2'b01,
    SDC_K_DATA = 2'b10
  } sdc_kind_t;
endpackage

// ==== src/sdc_smbus_ctrl.sv ====
// bus target, control and fault logic of the dual output video cable driver
`timescale 1ns/100ps

module sdc_smbus_ctrl #(
  parameter int unsigned TERM_SETTLE_CYC = sdc_pkg::TERM_CYC,  // enable time before sensing
  parameter int unsigned LOS_WIN_CYC     = 1024,               // activity window length
  parameter int unsigned LOS_MIN_EDGES   = 16,                 // fewer edges is noise
  parameter int unsigned LOS_MAX_EDGES   = 1000                // more edges is oscillation
) (
  input  wire logic       clk_i,                  // 50 MHz clock
  input  wire logic       srst_i,                 // sync reset, active high
  input  wire logic       scl_i,                  // bus clock pin level
  input  wire logic       sda_i,                  // bus data pin level
  output logic            sda_o,                  // bus data drive value (always 0)
  output logic            sda_oe_o,               // high while pulling data low
  input  wire logic       chain_release_in_i,     // chain release from upstream
  output logic            chain_release_out_o,    // chain release to downstream
  input  wire logic       edge_rate_select_i,     // high forces slow edges
  input  wire logic       enable_i,               // output enable pin
  input  wire logic       serial_video_in_i,      // input data activity
  input  wire logic [3:0] term_over_i,            // overamplitude per output leg
  output logic            edge_rate_slow_o,       // slow edge rate selected
  output logic            drv_a_en_o,             // output a driver on
  output logic            drv_b_en_o,             // output b driver on
  output logic            power_save_o,           // deep power save
  output logic            los_offset_o,           // add input offset
  output logic            signal_loss_flag_o,     // no valid input
  output logic            fault_o,                // fault drive value (always 0)
  output logic            fault_oe_o              // high while fault pulled low
);
  import sdc_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [8:0] sy1_q;
  logic [8:0] sy2_q;
  logic       scl_p_q;
  logic       sda_p_q;
  always_ff @(posedge clk_i) begin
    sy1_q <= {edge_rate_select_i, term_over_i, serial_video_in_i, enable_i, scl_i, sda_i};
    sy2_q <= sy1_q;
    scl_p_q <= sy2_q[1];
    sda_p_q <= sy2_q[0];
  end
  wire       sda_s   = sy2_q[0];
  wire       scl_s   = sy2_q[1];
  wire       en_s    = sy2_q[2];
  wire       vid_s   = sy2_q[3];
  wire [3:0] over_s  = sy2_q[7:4];
  wire       rst_int = srst_i | ~chain_release_in_i;

  wire start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;

  // ****************************************
  // idle detection
  // ****************************************
  logic [IDLE_CNT_W-1:0] hi_cnt_q;
  logic                  stop_seen_q;
  always_ff @(posedge clk_i) begin
    if (rst_int || !(scl_s && sda_s)) begin
      hi_cnt_q <= '0;
    end else if (hi_cnt_q != IDLE_CNT_W'(HIGH_MAX_CYC)) begin
      hi_cnt_q <= hi_cnt_q + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_int || start_ev) begin
      stop_seen_q <= 1'b0;
    end else if (stop_ev) begin
      stop_seen_q <= 1'b1;
    end
  end
  wire idle_to = (hi_cnt_q == IDLE_CNT_W'(HIGH_MAX_CYC))
               | (stop_seen_q & (hi_cnt_q >= IDLE_CNT_W'(BUF_CYC)));

  // ****************************************
  // bus target state machine
  // ****************************************
  sdc_state_t state_q;
  sdc_kind_t  kind_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic       rw_q;
  logic       oe_q;
  logic [6:0] dev_id_q;
  logic [7:0] rd_data;

  wire [7:0] rx_byte  = {sh_q[6:0], sda_s};
  wire       byte_end = (state_q == SDC_RX) & scl_rise & (bit_q == 3'h7);
  wire       addr_hit = rx_byte[7:1] == dev_id_q;
  wire       wr_now   = byte_end & (kind_q == SDC_K_DATA);

  always_ff @(posedge clk_i) begin
    if (rst_int || stop_ev || (idle_to && !start_ev)) begin
      state_q <= SDC_IDLE;
      oe_q    <= 1'b0;
    end else if (start_ev) begin
      state_q <= SDC_RX;
      kind_q  <= SDC_K_ADDR;
      bit_q   <= 3'h0;
      oe_q    <= 1'b0;
    end else begin
      case (state_q)
        SDC_RX: if (scl_rise) begin
          sh_q  <= rx_byte;
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            state_q <= SDC_AWT;
            if (kind_q == SDC_K_ADDR) begin
              rw_q <= sda_s;
              if (!addr_hit) begin
                state_q <= SDC_IGN;
              end
            end else if (kind_q == SDC_K_REG) begin
              ptr_q <= rx_byte;
            end
          end
        end
        SDC_AWT: if (scl_fall) begin
          oe_q    <= 1'b1;
          state_q <= SDC_ACK;
        end
        SDC_ACK: if (scl_fall) begin
          bit_q <= 3'h0;
          oe_q  <= 1'b0;
          if (kind_q == SDC_K_ADDR && rw_q) begin
            state_q <= SDC_TX;
            oe_q    <= ~rd_data[7];
            tx_q    <= {rd_data[6:0], 1'b0};
          end else if (kind_q == SDC_K_ADDR) begin
            state_q <= SDC_RX;
            kind_q  <= SDC_K_REG;
          end else if (kind_q == SDC_K_REG) begin
            state_q <= SDC_RX;
            kind_q  <= SDC_K_DATA;
          end else begin
            state_q <= SDC_IGN;
          end
        end
        SDC_TX: if (scl_fall) begin
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            oe_q    <= 1'b0;
            state_q <= SDC_HACK;
          end else begin
            oe_q <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        SDC_HACK: if (scl_rise) begin
          state_q <= SDC_IGN;
        end
        default: state_q <= state_q;
      endcase
    end
  end
  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_q;

  // ****************************************
  // registers
  // ****************************************
  logic [2:0] ctrl_q;
  logic [6:0] cfg_q;
  logic       chain_q;
  always_ff @(posedge clk_i) begin
    if (rst_int) begin
      dev_id_q <= DEV_ADDR_RST;
      ctrl_q   <= CTRL_RST;
      cfg_q    <= CFG_RST;
      chain_q  <= 1'b0;
    end else if (wr_now) begin
      if (ptr_q == REG_ID) begin
        dev_id_q <= rx_byte[7:1];
        chain_q  <= 1'b1;
      end else if (ptr_q == REG_CTRL) begin
        ctrl_q <= rx_byte[7:5];
      end else if (ptr_q == REG_CFG) begin
        cfg_q <= rx_byte[6:0];
      end
    end
  end
  assign chain_release_out_o = chain_q;

  // ****************************************
  // loss of signal
  // ****************************************
  logic [15:0] win_q;
  logic [15:0] edg_q;
  logic        vid_p_q;
  logic        present_q;
  wire         win_end = win_q == 16'(LOS_WIN_CYC - 1);
  wire         vid_edge = vid_s ^ vid_p_q;
  always_ff @(posedge clk_i) begin
    vid_p_q <= vid_s;
    if (rst_int) begin
      win_q     <= '0;
      edg_q     <= '0;
      present_q <= 1'b0;
    end else begin
      win_q <= win_end ? '0 : win_q + 16'h0001;
      edg_q <= win_end ? '0 : edg_q + {15'h0000, vid_edge};
      if (win_end) begin
        present_q <= edg_q >= 16'(LOS_MIN_EDGES)
                   && edg_q <= 16'(LOS_MAX_EDGES);
      end
    end
  end

  // ****************************************
  // enables and edge rate
  // ****************************************
  wire los_mute = cfg_q[CFG_LOS_MUTE];
  wire int_en   = en_s & ~(cfg_q[CFG_LOS_LINK] & ~present_q);
  wire out_ok   = int_en & ~(los_mute & ~present_q);
  assign drv_a_en_o         = out_ok & ~ctrl_q[CTRL_PD_A_BIT];
  assign drv_b_en_o         = out_ok & ~ctrl_q[CTRL_PD_B_BIT];
  assign power_save_o       = ~int_en;
  assign los_offset_o       = ~present_q & ~los_mute;
  assign signal_loss_flag_o = ~present_q;
  assign edge_rate_slow_o   = sy2_q[8] | ctrl_q[CTRL_SD_BIT];

  // ****************************************
  // termination sensing
  // ****************************************
  logic [31:0] on_cnt_q;
  logic [3:0]  tf_q;
  wire         settled = on_cnt_q == TERM_SETTLE_CYC;
  wire [3:0]   leg_en  = {{2{drv_b_en_o}}, {2{drv_a_en_o}}};
  always_ff @(posedge clk_i) begin
    if (rst_int || !int_en) begin
      on_cnt_q <= '0;
    end else if (!settled) begin
      on_cnt_q <= on_cnt_q + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_int) begin
      tf_q <= 4'h0;
    end else begin
      tf_q <= over_s & leg_en & {4{settled & present_q}};
    end
  end

  // ****************************************
  // fault pin and read data
  // ****************************************
  logic fault_q;
  wire  los_src = ~present_q & ~cfg_q[CFG_MASK_LOS];
  wire  tf_src  = |(tf_q & ~cfg_q[CFG_MASK_TF_LO +: 4]);
  always_ff @(posedge clk_i) begin
    if (rst_int) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= los_src | tf_src;
    end
  end
  assign fault_o    = 1'b0;
  assign fault_oe_o = fault_q;

  assign rd_data = (ptr_q == REG_ID)     ? {dev_id_q, 1'b0} :
                   (ptr_q == REG_STATUS) ? {3'h0, tf_q, present_q} :
                   (ptr_q == REG_CTRL)   ? {ctrl_q, 5'h00} :
                   (ptr_q == REG_CFG)    ? {1'b0, cfg_q} : 8'h00;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_int);

  sequence s_addr_byte;
    byte_end && kind_q == SDC_K_ADDR;
  endsequence

  foreign_addr_a: assert property (s_addr_byte and !addr_hit |=> state_q == SDC_IGN)
    else $error("foreign address not ignored");
  own_addr_ack_a: assert property (s_addr_byte and addr_hit |=> state_q == SDC_AWT)
    else $error("own address not accepted");
  ack_drive_a: assert property ($rose(oe_q) && state_q == SDC_ACK |-> $past(scl_fall))
    else $error("ack driven off clock fall");
  id_write_a: assert property (wr_now && ptr_q == REG_ID
      |=> chain_q && dev_id_q == $past(rx_byte[7:1]))
    else $error("id write did not load address");
  stop_idle_a: assert property (stop_ev |=> state_q == SDC_IDLE && !oe_q)
    else $error("stop did not release bus");
  logic [IDLE_CNT_W-1:0] busy_hi_q;
  always_ff @(posedge clk_i) begin
    if (rst_int || !(scl_s && sda_s) || state_q == SDC_IDLE) begin
      busy_hi_q <= '0;
    end else begin
      busy_hi_q <= busy_hi_q + 1'b1;
    end
  end
  high_to_a: assert property (busy_hi_q <= IDLE_CNT_W'(HIGH_MAX_CYC + 1))
    else $error("bus not idle after long high");
  fault_src_a: assert property (los_src |=> fault_oe_o)
    else $error("fault pin missed loss");
  masked_a: assert property (cfg_q[CFG_MASK_LOS] && tf_q == 4'h0 |=> !fault_oe_o)
    else $error("masked source drove fault");
  term_gate_a: assert property (!settled |=> tf_q == 4'h0)
    else $error("termination fault before settle");
  power_a: assert property (!en_s |-> power_save_o && !drv_a_en_o && !drv_b_en_o)
    else $error("drivers on with enable low");
endmodule

// ==== verif/sdc_host.sv ====
// bus host model that drives the clock and data lines of the control block
`timescale 1ns/100ps
module sdc_host (
  input  wire logic clk_i,      // 50 MHz clock
  input  wire logic sda_i,      // data line level
  output logic      scl_o,      // clock line level
  output logic      sda_pull_o  // high pulls data low
);
  import sdc_pkg::*;
  int unsigned lo_cyc = 4;  // raised for a slow host
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // ****************************************
  // line level steps
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic start_c();
    sda_pull_o <= 1'b0;
    tick(lo_cyc);
    scl_o <= 1'b1;
    tick(4);
    sda_pull_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
    tick(1);
  endtask
  task automatic stop_c();
    sda_pull_o <= 1'b1;
    tick(lo_cyc);
    scl_o <= 1'b1;
    tick(4);
    sda_pull_o <= 1'b0;
    tick(int'(BUF_CYC) + 4);
  endtask
  // data moves one cycle after the clock fall, never while it is high
  task automatic bit_x(input logic b, output logic r);
    sda_pull_o <= !b;
    tick(lo_cyc);
    scl_o <= 1'b1;
    tick(3);
    r = sda_i;
    scl_o <= 1'b0;
    tick(1);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic recv_byte(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, b[i]);
    bit_x(1'b1, r);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] rg, input logic [7:0] d,
                    output logic [2:0] acks);
    start_c();
    send_byte({a, 1'b0}, acks[2]);
    send_byte(rg, acks[1]);
    send_byte(d, acks[0]);
    stop_c();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] rg, output logic [7:0] d,
                    output logic [2:0] acks);
    start_c();
    send_byte({a, 1'b0}, acks[2]);
    send_byte(rg, acks[1]);
    start_c();
    send_byte({a, 1'b1}, acks[0]);
    recv_byte(d);
    stop_c();
  endtask
endmodule

// ==== verif/sdc_smbus_ctrl_bench.sv ====
// self-checking bench for the video driver control block
`timescale 1ns/100ps
module sdc_smbus_ctrl_bench;
  import sdc_pkg::*;
  logic clk_i = 1'b0, srst_i = 1'b1, chain_in = 1'b1, rate_pin = 1'b0, en_pin = 1'b1;
  logic vid = 1'b0;
  logic [3:0] over = 4'h0;
  logic scl_w, h_pull, sda_oe, fault_oe, fault_v, chain_out, slow, drv_a, drv_b, psave;
  logic loff, lflag;
  logic [6:0] addr = DEV_ADDR_RST;
  logic [7:0] rb;
  logic [2:0] acks;
  int n_fail = 0, checks_done = 0, tog_per = 0, tog_cnt = 0;
  wire sda_w = !(h_pull | sda_oe);  // open drain with pull-up
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    tog_cnt <= tog_cnt + 1;
    if (tog_per != 0 && tog_cnt % tog_per == 0)
      vid <= !vid;
  end
  sdc_host HOST (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_pull_o(h_pull));
  sdc_smbus_ctrl #(.TERM_SETTLE_CYC(50), .LOS_WIN_CYC(64), .LOS_MIN_EDGES(4),
                   .LOS_MAX_EDGES(40)) DUT (
    .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(),
    .sda_oe_o(sda_oe), .chain_release_in_i(chain_in), .chain_release_out_o(chain_out),
    .edge_rate_select_i(rate_pin), .enable_i(en_pin), .serial_video_in_i(vid),
    .term_over_i(over), .edge_rate_slow_o(slow), .drv_a_en_o(drv_a), .drv_b_en_o(drv_b),
    .power_save_o(psave), .los_offset_o(loff), .signal_loss_flag_o(lflag),
    .fault_o(fault_v), .fault_oe_o(fault_oe));
  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_f(input logic got, input logic exp);
    chk_b({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] rg, input logic [7:0] d, input logic [2:0] ea);
    HOST.wr(addr, rg, d, acks);
    chk_b({5'h00, acks}, {5'h00, ea});
  endtask
  task automatic rd(input logic [7:0] rg, input logic [7:0] ed);
    HOST.rd(addr, rg, rb, acks);
    chk_b({5'h00, acks}, 8'h07);
    chk_b(rb, ed);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_for(input bit fault_sel, input logic v);
    int k;
    for (k = 0; k < 400; k++) begin
      if ((fault_sel ? fault_oe : lflag) === v)
        break;
      tick(1);
    end
    chk_f(fault_sel ? fault_oe : lflag, v);
    if (k == 400)
      tally_and_finish();
  endtask
  task automatic done_t(input string s);
    $display("test %s finished", s);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    tick(10);
    srst_i <= 1'b0;
    tick(3);
    chk_f(lflag, 1'b1);
    chk_f(loff, 1'b1);
    chk_f(chain_out, 1'b0);
    chk_f(fault_oe, 1'b1);
    chk_f(fault_v, 1'b0);
    rd(REG_ID, {DEV_ADDR_RST, 1'b0});
    rd(8'h07, 8'h00);
    done_t("reset");
    rate_pin <= 1'b1;
    tick(3);
    chk_f(slow, 1'b1);
    rate_pin <= 1'b0;
    wr(REG_CTRL, 8'h80, 3'b111);
    chk_f(slow, 1'b1);
    rd(REG_CTRL, 8'h80);
    wr(REG_CTRL, 8'h40, 3'b111);
    chk_f(slow, 1'b0);
    chk_f(drv_b, 1'b0);
    chk_f(drv_a, 1'b1);
    en_pin <= 1'b0;
    tick(5);
    chk_f(drv_a, 1'b0);
    chk_f(psave, 1'b1);
    en_pin <= 1'b1;
    wr(REG_CTRL, 8'h00, 3'b111);
    done_t("rate and enable");
    tog_per <= 1;
    tick(200);
    chk_f(lflag, 1'b1);
    tog_per <= 4;
    wait_for(1'b0, 1'b0);
    tick(2);
    chk_f(loff, 1'b0);
    chk_f(fault_oe, 1'b0);
    rd(REG_STATUS, 8'h01);
    wr(REG_CFG, 8'h40, 3'b111);
    tog_per <= 0;
    wait_for(1'b0, 1'b1);
    tick(2);
    chk_f(psave, 1'b1);
    chk_f(drv_a, 1'b0);
    chk_f(fault_oe, 1'b1);
    chk_f(loff, 1'b1);
    wr(REG_CFG, 8'h21, 3'b111);
    chk_f(psave, 1'b0);
    chk_f(loff, 1'b0);
    chk_f(drv_a, 1'b0);
    chk_f(fault_oe, 1'b0);
    rd(REG_STATUS, 8'h00);
    wr(REG_CFG, 8'h00, 3'b111);
    done_t("loss");
    tog_per <= 4;
    wait_for(1'b0, 1'b0);
    en_pin <= 1'b0;
    tick(5);
    over <= 4'h1;
    tick(10);
    chk_f(fault_oe, 1'b0);
    en_pin <= 1'b1;
    tick(20);
    chk_f(fault_oe, 1'b0);
    wait_for(1'b1, 1'b1);
    rd(REG_STATUS, 8'h03);
    wr(REG_CFG, 8'h02, 3'b111);
    chk_f(fault_oe, 1'b0);
    rd(REG_STATUS, 8'h03);
    wr(REG_CFG, 8'h00, 3'b111);
    over <= 4'h0;
    wait_for(1'b1, 1'b0);
    rd(REG_STATUS, 8'h01);
    done_t("termination");
    HOST.lo_cyc = 12;
    addr = 7'h30;
    wr(REG_CTRL, 8'h80, 3'b000);
    chk_f(slow, 1'b0);
    addr = DEV_ADDR_RST;
    wr(REG_ID, 8'h2C, 3'b111);
    chk_f(chain_out, 1'b1);
    wr(REG_CTRL, 8'h80, 3'b000);
    chk_f(slow, 1'b0);
    addr = 7'h16;
    rd(REG_ID, 8'h2C);
    HOST.lo_cyc = 4;
    chain_in <= 1'b0;
    tick(3);
    chain_in <= 1'b1;
    tick(3);
    chk_f(chain_out, 1'b0);
    addr = DEV_ADDR_RST;
    rd(REG_ID, 8'h2E);
    done_t("address");
    tally_and_finish();
  end
endmodule
